//--- itc_asserts.sv
// concurrent checks on the timer bus interface ports
`timescale 1ns/10ps
`default_nettype none
module itc_asserts (
    input wire logic       clk_i,              // clock
    input wire logic       rst_n_i,            // reset, low
    input wire logic       cs_n_i,             // select
    input wire logic       rd_n_i,             // read strobe
    input wire logic       wr_n_i,             // write strobe
    input wire logic [1:0] port_select_bits_i, // port
    input wire logic [7:0] data_i,             // bus in
    input wire logic [7:0] data_o,             // bus out
    input wire logic       data_oe_n_o,        // drive enable
    input wire logic [2:0] count_out_o         // outputs
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // state seen right after reset
    reset_vals_a: assert property ($rose(rst_n_i) |-> data_oe_n_o
        && data_o == 8'h00 && count_out_o == 3'h0)
        else $error("reset values wrong");
    // bus driving starts only for selected reads
    read_select_a: assert property ($fell(data_oe_n_o) |->
        !$past(cs_n_i, 2) || !$past(cs_n_i, 3))
        else $error("bus driven without select");
    no_setup_read_a: assert property ($fell(data_oe_n_o) |->
        $past(port_select_bits_i, 2) != 2'h3)
        else $error("setup word port driven");
    read_answer_a: assert property ($fell(rd_n_i) && !cs_n_i
        && port_select_bits_i != 2'h3 |-> ##[3:4] !data_oe_n_o)
        else $error("read not answered");
    read_release_a: assert property ($rose(rd_n_i) |->
        ##[3:4] data_oe_n_o)
        else $error("bus not released");
    idle_float_a: assert property (rd_n_i [*5] |-> data_oe_n_o)
        else $error("bus driven while idle");
    read_hold_a: assert property (!data_oe_n_o && !rd_n_i |=>
        !data_oe_n_o)
        else $error("drive dropped mid read");
    setup_low_a: assert property ($rose(wr_n_i) && !cs_n_i
        && port_select_bits_i == 2'h3 && data_i[7:6] == 2'h0
        && data_i[5:4] != 2'h0 |-> ##[2:5] !count_out_o[0])
        else $error("output not low after setup");
    out_two_low_a: assert property ($rose(wr_n_i) && !cs_n_i
        && port_select_bits_i == 2'h3 && data_i[7:6] == 2'h2
        && data_i[5:4] != 2'h0 |-> ##[2:5] !count_out_o[2])
        else $error("output two not low after setup");
endmodule : itc_asserts
bind itc_timer itc_asserts u_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_i(data_i),
    .port_select_bits_i(port_select_bits_i), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .count_out_o(count_out_o));
`default_nettype wire

//--- itc_defs.svh
// constants of the interval timer bus and count path
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH
`define ITC_NUM_CHAN    3
`define ITC_ADDR_CTRL   2'h3
`define ITC_SEL_MSB     7
`define ITC_SEL_LSB     6
`define ITC_ACC_MSB     5
`define ITC_ACC_LSB     4
`define ITC_MODE_MSB    3
`define ITC_MODE_LSB    1
`define ITC_BCD_BIT     0
`define ITC_SEL_RDBK    2'h3
`define ITC_ACC_LATCH   2'h0
`define ITC_ACC_LO      2'h1
`define ITC_ACC_HI      2'h2
`define ITC_ACC_BOTH    2'h3
`define ITC_RB_CNT_N    5
`define ITC_RB_STAT_N   4
`define ITC_RB_CH0      1
`define ITC_CHAN_RST    69'h0
`define ITC_DATA_RST    8'h00
`endif

//--- itc_host.sv
// processor bus model that reads and writes the timer ports
`timescale 1ns/10ps
`default_nettype none
module itc_host (
    input  wire logic       clk_i,      // clock
    output logic            cs_n_o,     // select
    output logic            rd_n_o,     // read strobe
    output logic            wr_n_o,     // write strobe
    output logic      [1:0] addr_o,     // port
    output logic      [7:0] data_o,     // bus level at device
    input  wire logic [7:0] dev_data_i, // device data
    input  wire logic       dev_oe_n_i  // device drives, low
);
    logic       drv;  // host drives the bus
    logic [7:0] wdat; // byte being written
    logic [7:0] last; // previous bus level
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 2'h0;
        drv = 1'b0;
        wdat = 8'h00;
        last = 8'h00;
    end
    // released bus toggles so stale bytes never look valid
    assign data_o = drv ? wdat : ~last;
    always @(posedge clk_i) last <= data_o;
    // strobe low three clocks, then four clocks of recovery
    task automatic wr(input logic cs, input logic [1:0] a,
                      input logic [7:0] d);
        @(posedge clk_i);
        cs_n_o <= !cs;
        addr_o <= a;
        wdat <= d;
        drv <= 1'b1;
        wr_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        wr_n_o <= 1'b1;
        @(posedge clk_i);
        drv <= 1'b0;
        cs_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : wr
    // strobe low six clocks, keep the last driven byte
    task automatic rd(input logic cs, input logic [1:0] a,
                      output logic [7:0] q, output logic seen);
        @(posedge clk_i);
        cs_n_o <= !cs;
        addr_o <= a;
        rd_n_o <= 1'b0;
        seen = 1'b0;
        q = 8'h00;
        repeat (6) begin
            @(posedge clk_i);
            if (dev_oe_n_i === 1'b0) begin
                seen = 1'b1;
                q = dev_data_i;
            end
        end
        rd_n_o <= 1'b1;
        cs_n_o <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask : rd
endmodule : itc_host
`default_nettype wire

//--- itc_pkg.sv
// types shared by the interval timer bus and count path
`default_nettype none
package itc_pkg;
    // state held by one counter channel
    typedef struct packed {
        logic [5:0]  ctrl;    // access, mode and decimal bits
        logic [7:0]  cr_lo;   // load_hold_low
        logic [7:0]  cr_hi;   // load_hold_high
        logic [15:0] ce;      // counting element
        logic [15:0] ol;      // readback_latch
        logic [7:0]  stat;    // latched status byte
        logic        frozen;  // readback_latch holds a count
        logic        stat_ok; // status byte waits to be read
        logic        wr_hi;   // next count write fills high half
        logic        rd_hi;   // next count read returns high half
        logic        pend;    // load_hold_register waits for transfer
        logic        nul;     // null count flag
        logic        out;     // counter output level
    } itc_chan_t;
endpackage : itc_pkg
`default_nettype wire

//--- itc_timer.sv
// bus interface and three counter data paths of the interval timer
`timescale 1ns/10ps
`default_nettype none
`include "itc_defs.svh"

// What this block does
// - address 00,01,10 counters; 11 setup word
// - strobes ignored unless device select low
// - read strobe returns selected counter value
// - write strobe takes setup word or count
// - setup word write programs the channel
// - setup word cannot be read back directly
// - status holds setup, output, null flag
// - sixteen bit presettable down counter
// - readback latch tracks, freezes, then resumes
// - latch read one byte half at once
// - count reads only through readback latch
// - counts land in load register first
// - byte-wise load, both halves moved together
// - single byte access clears other half
// - three identical independent channels
// - data bus driven only in selected reads
// - no bus path into counting element
// - setup word fields: pick, access, mode, decimal
// - access 01 low, 10 high, 11 both
// - access 00 means latch the count
module itc_timer (
    input  wire logic       clk_i,              // 20 MHz system clock
    input  wire logic       rst_n_i,            // sync reset, active low
    input  wire logic       cs_n_i,             // device select, low
    input  wire logic       rd_n_i,             // read strobe, low
    input  wire logic       wr_n_i,             // write strobe, low
    input  wire logic [1:0] port_select_bits_i, // port address
    input  wire logic [7:0] data_i,             // data bus, in
    output logic      [7:0] data_o,             // data bus, out
    output logic            data_oe_n_o,        // low while driving
    input  wire logic [2:0] count_clk_i,        // channel count clocks
    input  wire logic [2:0] gate_i,             // channel gates
    output logic      [2:0] count_out_o         // channel outputs
);

    // decrement in binary or four-decade decimal
    function automatic logic [15:0] itc_dec(input logic [15:0] v,
                                            input logic        bcd);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (b) begin
                    if (r[i*4 +: 4] == 4'h0) begin
                        r[i*4 +: 4] = 4'h9;
                    end else begin
                        r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                        b = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : itc_dec

    // byte a channel presents on a read
    function automatic logic [7:0] itc_rd_byte(input itc_pkg::itc_chan_t c);
        logic [1:0] acc;
        acc = c.ctrl[`ITC_ACC_MSB:`ITC_ACC_LSB];
        if (c.stat_ok) begin
            return c.stat;
        end
        case (acc)
            `ITC_ACC_HI:   return c.ol[15:8];
            `ITC_ACC_BOTH: return c.rd_hi ? c.ol[15:8]
                                          : c.ol[7:0];
            default:       return c.ol[7:0];
        endcase
    endfunction : itc_rd_byte

    // synchroniser and edge stages
    logic       rd_s1, rd_s2, rd_s3;
    logic       wr_s1, wr_s2, wr_s3;
    logic [2:0] cclk_s1, cclk_s2, cclk_s3;
    logic [2:0] gate_s1, gate_s2;

    // write capture while strobe is low
    logic       wr_cs;
    logic [1:0] wr_addr;
    logic [7:0] wr_data;
    logic       next_wr_cs;
    logic [1:0] next_wr_addr;
    logic [7:0] next_wr_data;

    // read side state
    logic       rd_drive;
    logic [1:0] rd_addr;
    logic       next_rd_drive;
    logic [1:0] next_rd_addr;
    logic [7:0] next_data;

    itc_pkg::itc_chan_t ch      [`ITC_NUM_CHAN];
    itc_pkg::itc_chan_t next_ch [`ITC_NUM_CHAN];

    // strobe edges seen in the clock domain
    logic wr_end, rd_start, rd_end;
    assign wr_end   = wr_s2 & ~wr_s3;
    assign rd_start = ~rd_s2 & rd_s3;
    assign rd_end   = rd_s2 & ~rd_s3;

    assign data_oe_n_o = ~rd_drive;
    always_comb begin
        for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
            count_out_o[i] = ch[i].out;
        end
    end

    // next values of bus capture, read drive and channels
    always_comb begin
        logic [1:0] acc;
        logic [7:0] d;
        next_wr_cs    = wr_cs;
        next_wr_addr  = wr_addr;
        next_wr_data  = wr_data;
        next_rd_drive = rd_drive;
        next_rd_addr  = rd_addr;
        next_data     = data_o;
        next_ch       = ch;
        acc           = 2'h0;
        d             = wr_data;

        // sample address, data and select during the write pulse
        if (!wr_n_i) begin
            next_wr_cs   = ~cs_n_i;
            next_wr_addr = port_select_bits_i;
            next_wr_data = data_i;
        end

        // latch tracks the counting element unless frozen
        for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
            if (!ch[i].frozen) begin
                next_ch[i].ol = ch[i].ce;
            end
        end

        // count clock rising edge: transfer or decrement
        for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
            if (cclk_s2[i] && !cclk_s3[i]) begin
                if (ch[i].pend) begin
                    next_ch[i].ce   = {ch[i].cr_hi, ch[i].cr_lo};
                    next_ch[i].pend = 1'b0;
                    next_ch[i].nul  = 1'b0;
                end else if (gate_s2[i]) begin
                    next_ch[i].ce = itc_dec(ch[i].ce,
                                            ch[i].ctrl[`ITC_BCD_BIT]);
                    if (ch[i].ce == 16'h0001) begin
                        next_ch[i].out = 1'b1;
                    end
                end
            end
        end

        // committed write at the end of the write strobe
        if (wr_end && wr_cs) begin
            if (wr_addr == `ITC_ADDR_CTRL) begin
                if (d[`ITC_SEL_MSB:`ITC_SEL_LSB] == `ITC_SEL_RDBK) begin
                    for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
                        if (d[`ITC_RB_CH0 + i]) begin
                            if (!d[`ITC_RB_CNT_N] && !ch[i].frozen) begin
                                next_ch[i].frozen = 1'b1;
                            end
                            if (!d[`ITC_RB_STAT_N] && !ch[i].stat_ok) begin
                                next_ch[i].stat = {ch[i].out, ch[i].nul,
                                                   ch[i].ctrl};
                                next_ch[i].stat_ok = 1'b1;
                            end
                        end
                    end
                end else begin
                    for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
                        if (d[`ITC_SEL_MSB:`ITC_SEL_LSB] == 2'(i)) begin
                            if (d[`ITC_ACC_MSB:`ITC_ACC_LSB]
                                    == `ITC_ACC_LATCH) begin
                                if (!ch[i].frozen) begin
                                    next_ch[i].frozen = 1'b1;
                                end
                            end else begin
                                next_ch[i].ctrl   = d[5:0];
                                next_ch[i].wr_hi  = 1'b0;
                                next_ch[i].rd_hi  = 1'b0;
                                next_ch[i].frozen = 1'b0;
                                next_ch[i].nul    = 1'b1;
                                next_ch[i].out    = 1'b0;
                            end
                        end
                    end
                end
            end else begin
                for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
                    if (wr_addr == 2'(i)) begin
                        acc = ch[i].ctrl[`ITC_ACC_MSB:`ITC_ACC_LSB];
                        next_ch[i].nul = 1'b1;
                        case (acc)
                            `ITC_ACC_LO: begin
                                next_ch[i].cr_lo = d;
                                next_ch[i].cr_hi = 8'h00;
                                next_ch[i].pend  = 1'b1;
                            end
                            `ITC_ACC_HI: begin
                                next_ch[i].cr_hi = d;
                                next_ch[i].cr_lo = 8'h00;
                                next_ch[i].pend  = 1'b1;
                            end
                            `ITC_ACC_BOTH: begin
                                if (!ch[i].wr_hi) begin
                                    next_ch[i].cr_lo = d;
                                    next_ch[i].wr_hi = 1'b1;
                                end else begin
                                    next_ch[i].cr_hi = d;
                                    next_ch[i].wr_hi = 1'b0;
                                    next_ch[i].pend  = 1'b1;
                                end
                            end
                            default: begin
                                next_ch[i].nul = ch[i].nul; // unprogrammed
                            end
                        endcase
                    end
                end
            end
        end

        // read start: pick byte and drive the bus
        if (rd_start && !cs_n_i) begin
            next_rd_addr = port_select_bits_i;
            if (port_select_bits_i != `ITC_ADDR_CTRL) begin
                next_rd_drive = 1'b1;
                for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
                    if (port_select_bits_i == 2'(i)) begin
                        next_data = itc_rd_byte(ch[i]);
                    end
                end
            end
        end

        // read end: release the bus, advance pointer
        if (rd_end && rd_drive) begin
            next_rd_drive = 1'b0;
            for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
                if (rd_addr == 2'(i)) begin
                    acc = ch[i].ctrl[`ITC_ACC_MSB:`ITC_ACC_LSB];
                    if (ch[i].stat_ok) begin
                        next_ch[i].stat_ok = 1'b0;
                    end else if (acc == `ITC_ACC_BOTH && !ch[i].rd_hi) begin
                        next_ch[i].rd_hi = 1'b1;
                    end else begin
                        next_ch[i].rd_hi  = 1'b0;
                        if (ch[i].frozen) begin              // release wins over a new latch
                            next_ch[i].frozen = 1'b0;
                        end
                    end
                end
            end
        end
    end

    // register stage for all state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_s1    <= 1'b1;
            rd_s2    <= 1'b1;
            rd_s3    <= 1'b1;
            wr_s1    <= 1'b1;
            wr_s2    <= 1'b1;
            wr_s3    <= 1'b1;
            cclk_s1  <= 3'h0;
            cclk_s2  <= 3'h0;
            cclk_s3  <= 3'h0;
            gate_s1  <= 3'h0;
            gate_s2  <= 3'h0;
            wr_cs    <= 1'b0;
            wr_addr  <= 2'h0;
            wr_data  <= `ITC_DATA_RST;
            rd_drive <= 1'b0;
            rd_addr  <= 2'h0;
            data_o   <= `ITC_DATA_RST;
            for (int i = 0; i < `ITC_NUM_CHAN; i++) begin
                ch[i] <= `ITC_CHAN_RST;
            end
        end else begin
            rd_s1    <= rd_n_i;
            rd_s2    <= rd_s1;
            rd_s3    <= rd_s2;
            wr_s1    <= wr_n_i;
            wr_s2    <= wr_s1;
            wr_s3    <= wr_s2;
            cclk_s1  <= count_clk_i;
            cclk_s2  <= cclk_s1;
            cclk_s3  <= cclk_s2;
            gate_s1  <= gate_i;
            gate_s2  <= gate_s1;
            wr_cs    <= next_wr_cs;
            wr_addr  <= next_wr_addr;
            wr_data  <= next_wr_data;
            rd_drive <= next_rd_drive;
            rd_addr  <= next_rd_addr;
            data_o   <= next_data;
            ch       <= next_ch;
        end
    end

endmodule : itc_timer
`default_nettype wire

//--- testbench.sv
// self-checking bench for the interval timer bus and count path
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_i;
    logic        rst_n_i;
    logic        cs_n, rd_n, wr_n, oe_n, seen;
    logic [1:0]  addr, c;
    logic [7:0]  din, dout, q;
    logic [2:0]  cclk, gate, cout;
    logic [15:0] v;
    logic [15:0] val [3];
    int          n_fail, samples_checked;
    itc_timer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .port_select_bits_i(addr),
        .data_i(din), .data_o(dout), .data_oe_n_o(oe_n),
        .count_clk_i(cclk), .gate_i(gate), .count_out_o(cout));
    itc_host u_host (.clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .addr_o(addr), .data_o(din), .dev_data_i(dout),
        .dev_oe_n_i(oe_n));
    task automatic check(input string what, input logic [15:0] got,
                         input logic [15:0] exp_v);
        samples_checked++;
        if (got !== exp_v) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp_v, got);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // count clock pulses spaced well beyond the sync delay
    task automatic tick(input logic [1:0] ch, input int n);
        repeat (n) begin
            @(posedge clk_i);
            cclk[ch] <= 1'b1;
            repeat (4) @(posedge clk_i);
            cclk[ch] <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask : tick
    // two-byte count read, low half first
    task automatic get16(input logic [1:0] ch, output logic [15:0] r);
        u_host.rd(1'b1, ch, r[7:0], seen);
        u_host.rd(1'b1, ch, r[15:8], seen);
    endtask : get16
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // watchdog far beyond the expected run
    initial begin
        #2000000;
        n_fail++;
        conclude();
    end
    initial begin
        rst_n_i = 1'b0;
        cclk = 3'h0;
        gate = 3'h0;
        n_fail = 0;
        samples_checked = 0;
        val[0] = 16'h1234;
        val[1] = 16'hA5C3;
        val[2] = 16'h0002;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int ch = 0; ch < 3; ch++) begin
            c = ch[1:0];
            u_host.wr(1'b1, 2'h3, {c, 2'h3, ch[2:0], 1'b0});
            u_host.wr(1'b1, c, val[ch][7:0]);
            u_host.wr(1'b1, c, val[ch][15:8]);
            tick(c, 1);
            u_host.wr(1'b1, 2'h3, {c, 6'h00});
            gate[ch] <= 1'b1;
            tick(c, 2);
            get16(c, v);
            check("frozen count", v, val[ch]);
            get16(c, v);
            check("count after two steps", v, val[ch] - 16'h2);
        end
        get16(2'h0, v);
        check("channel 0 untouched", v, val[0] - 16'h2);
        check("outputs", {13'h0, cout}, 16'h4);
        u_host.wr(1'b0, 2'h3, 8'h90);
        check("unselected write", {13'h0, cout}, 16'h4);
        u_host.rd(1'b0, 2'h0, q, seen);
        check("unselected read drive", {15'h0, seen}, 16'h0);
        u_host.wr(1'b1, 2'h3, 8'hE2);
        u_host.rd(1'b1, 2'h0, q, seen);
        check("status byte", {8'h00, q}, 16'h0030);
        u_host.rd(1'b1, 2'h3, q, seen);
        check("setup port drive", {15'h0, seen}, 16'h0);
        gate[1] <= 1'b0;
        u_host.wr(1'b1, 2'h3, 8'h60);
        u_host.wr(1'b1, 2'h1, 8'h5A);
        tick(2'h1, 1);
        u_host.wr(1'b1, 2'h3, 8'h40);
        u_host.rd(1'b1, 2'h1, q, seen);
        check("high byte only", {8'h00, q}, 16'h005A);
        u_host.wr(1'b1, 2'h3, 8'h50);
        u_host.wr(1'b1, 2'h3, 8'h40);
        u_host.rd(1'b1, 2'h1, q, seen);
        check("cleared low half", {8'h00, q}, 16'h0000);
        // decimal counting and read-back count latch on channel 0
        u_host.wr(1'b1, 2'h3, 8'h31);
        u_host.wr(1'b1, 2'h0, 8'h00);
        u_host.wr(1'b1, 2'h0, 8'h10);
        tick(2'h0, 2);
        u_host.wr(1'b1, 2'h3, 8'hD2);
        tick(2'h0, 1);
        get16(2'h0, v);
        check("decimal step", v, 16'h0999);
        get16(2'h0, v);
        check("latch released", v, 16'h0998);
        // a new setup word drops channel 2 output again
        u_host.wr(1'b1, 2'h3, 8'hB4);
        check("output after setup", {13'h0, cout}, 16'h0);
        conclude();
    end
endmodule : testbench
`default_nettype wire
